// ### rtl/sars_sequencer.sv
`timescale 1ns/1ps
`include "sars_params.svh"
// Overview of operation
// - three modes: single channel, repeating round robin, one-time sweep.
// - single mode converts the firmware channel, then interrupts the core.
// - after converter enable, wait the programmed settling time before sampling.
// - sample for the programmed sampling time, then begin conversion.
// - conversion lasts exactly twelve clock cycles.
// - on completion store result; in single mode pulse the core interrupt two cycles.
// - single continuous mode restarts sampling once the interrupt interval ends.
// - round robin converts channels 0 to 11 into separate result registers.
// - result registers readable any time without stalling the sequence.
// - each new round robin conversion overwrites that channel's result.
// - default timing gives about 63.33 us per channel, 760 us sweep.
// - one-time mode sweeps like round robin but stops after last channel.
// - one-time mode interrupts the core once after the sweep ends.
// - each result is ten bits from successive approximation.
module sars_sequencer
    import sars_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic adc_en,
    output logic [4:0] mux_sel,
    output logic sample_hold,
    output logic [9:0] sar_code,
    input wire logic comp_in,
    output logic core_int,
    output logic irq
);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic [31:0] merge_word(input logic [31:0] old_w,
                                               input logic [31:0] new_w,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        return (a[1:0] == 2'h0) &&
               ((a <= `SARS_SINGLE_RES_OFS) ||
                ((a >= `SARS_RES_BASE_OFS) &&
                 (a < `SARS_RES_BASE_OFS + 8'(4 * `SARS_NUM_RES))));
    endfunction

    function automatic logic [15:0] at_least_one(input logic [15:0] v);
        return (v == 16'h0000) ? 16'h0001 : v;
    endfunction

    // write channel state
    logic [7:0] aw_q_r;
    logic [31:0] w_q_r;
    logic [3:0] strb_q_r;
    logic aw_full_r;
    logic w_full_r;
    logic wr_fire;
    logic [31:0] wr_merged;

    // configuration and status
    sars_cfg_t cfg_r;
    logic start_pend_r;
    logic [15:0] settle_r;
    logic [15:0] sample_r;
    sars_irq_t int_stat_r;
    sars_irq_t int_mask_r;
    sars_irq_t ev_r;
    logic [31:0] cfg_word;

    // sequencer
    sars_state_t state_r;
    logic [15:0] cnt_r;
    sars_mode_t mode_r;
    logic [9:0] single_res_r;
    logic [9:0] res_r [`SARS_NUM_RES];
    logic go;
    logic launch;
    logic settle_done;
    logic again;
    logic [4:0] next_chan;
    logic [31:0] rdata_nxt;

    assign wr_fire = aw_full_r && w_full_r && !s_axi_bvalid;

    always_comb begin
        cfg_word = 32'h0000_0000;
        cfg_word[`SARS_CTRL_EN_BIT] = cfg_r.en;
        cfg_word[`SARS_CTRL_MODE_LSB +: 2] = cfg_r.mode;
        cfg_word[`SARS_CTRL_CONT_BIT] = cfg_r.cont;
        cfg_word[`SARS_CTRL_CHAN_LSB +: 5] = cfg_r.chan;
        wr_merged = merge_word(cfg_word, w_q_r, strb_q_r);
        if (aw_q_r == `SARS_SETTLE_OFS) begin
            wr_merged = merge_word({16'h0000, settle_r}, w_q_r, strb_q_r);
        end else if (aw_q_r == `SARS_SAMPLE_OFS) begin
            wr_merged = merge_word({16'h0000, sample_r}, w_q_r, strb_q_r);
        end else if (aw_q_r == `SARS_INT_MASK_OFS) begin
            wr_merged = merge_word({29'h0000_0000, int_mask_r}, w_q_r, strb_q_r);
        end
    end

    // address and data may arrive in either order; both are held until the write lands
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            aw_q_r <= 8'h00;
            w_q_r <= 32'h0000_0000;
            strb_q_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q_r <= s_axi_awaddr;
                aw_full_r <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q_r <= s_axi_wdata;
                strb_q_r <= s_axi_wstrb;
                w_full_r <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_mapped(aw_q_r) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // control word; the sequencer samples it only at conversion boundaries
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= '{chan: 5'h00, cont: 1'b0, mode: SARS_MODE_SINGLE, en: 1'b0};
        end else if (wr_fire && aw_q_r == `SARS_CTRL_OFS) begin
            cfg_r.en <= wr_merged[`SARS_CTRL_EN_BIT];
            cfg_r.cont <= wr_merged[`SARS_CTRL_CONT_BIT];
            cfg_r.chan <= wr_merged[`SARS_CTRL_CHAN_LSB +: 5];
            // the fourth mode code is not a mode: keep the old one
            if (wr_merged[`SARS_CTRL_MODE_LSB +: 2] != 2'h3) begin
                cfg_r.mode <= sars_mode_t'(wr_merged[`SARS_CTRL_MODE_LSB +: 2]);
            end
        end
    end

    // start request; a new request in the launch cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            start_pend_r <= 1'b0;
        end else begin
            if (launch) begin
                start_pend_r <= 1'b0;
            end
            if (wr_fire && aw_q_r == `SARS_CTRL_OFS && strb_q_r[3] &&
                w_q_r[`SARS_CTRL_START_BIT]) begin
                start_pend_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            settle_r <= `SARS_SETTLE_RST;
            sample_r <= 16'(`SARS_SAMPLE_RST_32);
            int_mask_r <= `SARS_MASK_RST;
        end else if (wr_fire) begin
            if (aw_q_r == `SARS_SETTLE_OFS) begin
                settle_r <= wr_merged[15:0];
            end
            if (aw_q_r == `SARS_SAMPLE_OFS) begin
                sample_r <= wr_merged[15:0];
            end
            if (aw_q_r == `SARS_INT_MASK_OFS) begin
                int_mask_r <= wr_merged[2:0];
            end
        end
    end

    // sticky status, write one to clear; an event in the clear cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_r <= 3'h0;
        end else begin
            if (wr_fire && aw_q_r == `SARS_INT_STAT_OFS && strb_q_r[0]) begin
                int_stat_r <= (int_stat_r & ~w_q_r[2:0]) | ev_r;
            end else begin
                int_stat_r <= int_stat_r | ev_r;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat_r & int_mask_r);
        end
    end

    // mode 3 cannot reach cfg_r, so every code here is legal
    assign go = start_pend_r || cfg_r.mode == SARS_MODE_RR ||
                (cfg_r.mode == SARS_MODE_SINGLE && cfg_r.cont);
    assign settle_done = (cnt_r + 16'h0001) >= at_least_one(settle_r);
    assign launch = cfg_r.en && go &&
                    ((state_r == SARS_ST_IDLE && adc_en) ||
                     (state_r == SARS_ST_SETTLE && settle_done));

    // what follows the interrupt interval
    always_comb begin
        again = 1'b0;
        next_chan = cfg_r.chan;
        if (cfg_r.en && cfg_r.mode == mode_r) begin
            unique case (mode_r)
                SARS_MODE_SINGLE: begin
                    again = cfg_r.cont;
                    next_chan = cfg_r.chan;
                end
                SARS_MODE_RR: begin
                    again = 1'b1;
                    next_chan = (mux_sel == `SARS_LAST_CH) ? 5'h00 : mux_sel + 5'h01;
                end
                SARS_MODE_ONCE: begin
                    again = (mux_sel != `SARS_LAST_CH);
                    next_chan = mux_sel + 5'h01;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= SARS_ST_IDLE;
            cnt_r <= 16'h0000;
            mode_r <= SARS_MODE_SINGLE;
            adc_en <= 1'b0;
            mux_sel <= 5'h00;
            sample_hold <= 1'b0;
            sar_code <= 10'h000;
            core_int <= 1'b0;
            ev_r <= 3'h0;
        end else begin
            ev_r <= 3'h0;
            unique case (state_r)
                SARS_ST_IDLE: begin
                    if (!cfg_r.en) begin
                        adc_en <= 1'b0;
                    end else if (!adc_en) begin
                        adc_en <= 1'b1;
                        state_r <= SARS_ST_SETTLE;
                        cnt_r <= 16'h0000;
                    end
                end
                SARS_ST_SETTLE: begin
                    if (!settle_done) begin
                        cnt_r <= cnt_r + 16'h0001;
                    end else if (!launch) begin
                        state_r <= SARS_ST_IDLE;
                    end
                end
                SARS_ST_SAMPLE: begin
                    if ((cnt_r + 16'h0001) >= at_least_one(sample_r)) begin
                        sample_hold <= 1'b0;
                        state_r <= SARS_ST_CONVERT;
                        cnt_r <= 16'h0000;
                        sar_code <= 10'h200;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                SARS_ST_CONVERT: begin
                    // ten trial steps, MSB first; the last two cycles are fixed overhead
                    if (cnt_r < 16'h000A) begin
                        if (!comp_in) begin
                            sar_code[4'(9 - cnt_r[3:0])] <= 1'b0;
                        end
                        if (cnt_r < 16'h0009) begin
                            sar_code[4'(8 - cnt_r[3:0])] <= 1'b1;
                        end
                    end
                    if (cnt_r == `SARS_CONV_CYCLES - 16'h0001) begin
                        state_r <= SARS_ST_INTA;
                        cnt_r <= 16'h0000;
                        ev_r.conv <= 1'b1;
                        ev_r.wrap <= mode_r == SARS_MODE_RR && mux_sel == `SARS_LAST_CH;
                        ev_r.once <= mode_r == SARS_MODE_ONCE && mux_sel == `SARS_LAST_CH;
                        // core pulse per single conversion, once per one-time sweep
                        core_int <= mode_r == SARS_MODE_SINGLE ||
                                    (mode_r == SARS_MODE_ONCE && mux_sel == `SARS_LAST_CH);
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                SARS_ST_INTA: begin
                    if (cnt_r == `SARS_INTA_CYCLES - 16'h0001) begin
                        core_int <= 1'b0;
                        cnt_r <= 16'h0000;
                        if (again) begin
                            state_r <= SARS_ST_SAMPLE;
                            sample_hold <= 1'b1;
                            mux_sel <= next_chan;
                        end else begin
                            state_r <= SARS_ST_IDLE;
                        end
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
            endcase
            if (launch) begin
                state_r <= SARS_ST_SAMPLE;
                cnt_r <= 16'h0000;
                sample_hold <= 1'b1;
                mode_r <= cfg_r.mode;
                mux_sel <= (cfg_r.mode == SARS_MODE_SINGLE) ? cfg_r.chan : 5'h00;
            end
        end
    end

    // results land only on the final conversion cycle, never partially
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            single_res_r <= 10'h000;
            for (int i = 0; i < `SARS_NUM_RES; i++) begin
                res_r[i] <= 10'h000;
            end
        end else if (state_r == SARS_ST_CONVERT &&
                     cnt_r == `SARS_CONV_CYCLES - 16'h0001) begin
            if (mode_r == SARS_MODE_SINGLE) begin
                single_res_r <= sar_code;
            end else begin
                res_r[4'(mux_sel)] <= sar_code;
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (s_axi_araddr == `SARS_CTRL_OFS) begin
            rdata_nxt = cfg_word;
        end else if (s_axi_araddr == `SARS_SETTLE_OFS) begin
            rdata_nxt = {16'h0000, settle_r};
        end else if (s_axi_araddr == `SARS_SAMPLE_OFS) begin
            rdata_nxt = {16'h0000, sample_r};
        end else if (s_axi_araddr == `SARS_STATUS_OFS) begin
            rdata_nxt[`SARS_STAT_BUSY_BIT] = state_r != SARS_ST_IDLE;
            rdata_nxt[`SARS_STAT_ADC_EN_BIT] = adc_en;
            rdata_nxt[`SARS_STAT_CHAN_LSB +: 5] = mux_sel;
            rdata_nxt[`SARS_STAT_MODE_LSB +: 2] = mode_r;
        end else if (s_axi_araddr == `SARS_INT_STAT_OFS) begin
            rdata_nxt = {29'h0000_0000, int_stat_r};
        end else if (s_axi_araddr == `SARS_INT_MASK_OFS) begin
            rdata_nxt = {29'h0000_0000, int_mask_r};
        end else if (s_axi_araddr == `SARS_SINGLE_RES_OFS) begin
            rdata_nxt = {22'h00_0000, single_res_r};
        end else if (addr_mapped(s_axi_araddr)) begin
            rdata_nxt = {22'h00_0000, res_r[4'((s_axi_araddr - `SARS_RES_BASE_OFS) >> 2)]};
        end
    end

    // reads touch no sequencer state, so they never stall a sweep
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rdata_nxt;
                s_axi_rresp <= addr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

endmodule

// ### rtl/sars_params.svh
`ifndef SARS_PARAMS_SVH
`define SARS_PARAMS_SVH

// register byte offsets
`define SARS_CTRL_OFS 8'h00
`define SARS_SETTLE_OFS 8'h04
`define SARS_SAMPLE_OFS 8'h08
`define SARS_STATUS_OFS 8'h0C
`define SARS_INT_STAT_OFS 8'h10
`define SARS_INT_MASK_OFS 8'h14
`define SARS_SINGLE_RES_OFS 8'h18
`define SARS_RES_BASE_OFS 8'h40

// control word fields
`define SARS_CTRL_EN_BIT 0
`define SARS_CTRL_MODE_LSB 1
`define SARS_CTRL_CONT_BIT 3
`define SARS_CTRL_CHAN_LSB 4
`define SARS_CTRL_START_BIT 31

// status word fields
`define SARS_STAT_BUSY_BIT 0
`define SARS_STAT_ADC_EN_BIT 1
`define SARS_STAT_CHAN_LSB 2
`define SARS_STAT_MODE_LSB 7

// interrupt status / mask bits
`define SARS_IRQ_CONV_BIT 0
`define SARS_IRQ_ONCE_BIT 1
`define SARS_IRQ_WRAP_BIT 2

// mode codes
`define SARS_MODE_SINGLE_V 2'h0
`define SARS_MODE_RR_V 2'h1
`define SARS_MODE_ONCE_V 2'h2

// sweep covers channels 0 to this index
`define SARS_LAST_CH 5'h0B
`define SARS_NUM_RES 12

// reset values
`define SARS_SETTLE_RST 16'h0064
`define SARS_MASK_RST 3'h0

// timing
`define SARS_CLK_NS 32'h0000000A
`define SARS_CH_TIME_NS 32'h0000F762
`define SARS_CONV_CYCLES 16'h000C
`define SARS_INTA_CYCLES 16'h0002
`define SARS_SAMPLE_RST_32 \
    ((`SARS_CH_TIME_NS / `SARS_CLK_NS) - 32'(`SARS_CONV_CYCLES) - 32'(`SARS_INTA_CYCLES))

`endif

// ### rtl/sars_pkg.sv
`include "sars_params.svh"

package sars_pkg;

    typedef enum logic [1:0] {
        SARS_MODE_SINGLE = `SARS_MODE_SINGLE_V,
        SARS_MODE_RR = `SARS_MODE_RR_V,
        SARS_MODE_ONCE = `SARS_MODE_ONCE_V
    } sars_mode_t;

    typedef enum logic [2:0] {
        SARS_ST_IDLE,
        SARS_ST_SETTLE,
        SARS_ST_SAMPLE,
        SARS_ST_CONVERT,
        SARS_ST_INTA
    } sars_state_t;

    typedef struct packed {
        logic [4:0] chan;
        logic cont;
        sars_mode_t mode;
        logic en;
    } sars_cfg_t;

    typedef struct packed {
        logic wrap;
        logic once;
        logic conv;
    } sars_irq_t;

endpackage

// ### verification/sars_sequencer_checker.sv
`timescale 1ns/1ps
module sars_sequencer_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic adc_en,
    input wire logic [4:0] mux_sel,
    input wire logic sample_hold,
    input wire logic core_int
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_INT_TWO: assert property ($rose(core_int) |=> core_int ##1 !core_int)
        else $error("core interrupt pulse is not two cycles");
    AST_CONV_TO_INT: assert property ($rose(core_int) |->
        $past(sample_hold, 13) && !$past(sample_hold, 12) && !$past(sample_hold, 1))
        else $error("interrupt not twelve cycles after sampling");
    // conversion plus interrupt interval keeps the input out of sampling
    AST_CONV_QUIET: assert property ($fell(sample_hold) |-> !sample_hold [*8] ##1 !sample_hold [*6])
        else $error("sampling restarted inside conversion");
    AST_MUX_HOLD: assert property ($fell(sample_hold) |-> $stable(mux_sel) [*8])
        else $error("channel changed during conversion");
    AST_EN_THRU: assert property ($fell(sample_hold) |-> adc_en [*8] ##1 adc_en [*6])
        else $error("converter disabled inside conversion");
    AST_SETTLE_FIRST: assert property ($rose(adc_en) |-> !sample_hold)
        else $error("sampling without settling");
    AST_READ_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write answer timing wrong");
endmodule

// ### verification/sars_adc_model.sv
`timescale 1ns/1ps
module sars_adc_model (
    input wire logic aclk,
    input wire logic adc_en,
    input wire logic [4:0] mux_sel,
    input wire logic sample_hold,
    input wire logic [9:0] sar_code,
    input wire logic [9:0] offset,
    output logic comp_in
);
    logic [9:0] held_r;
    logic tog_r = 1'b0;
    always_ff @(posedge aclk) begin
        tog_r <= ~tog_r;
        if (sample_hold) begin
            held_r <= 10'({5'h00, mux_sel} * 10'h045 + offset);
        end
    end
    // powered down: a toggling line so a stale comparator bit is never trusted
    assign comp_in = adc_en ? (held_r >= sar_code) : tog_r;
endmodule

// ### verification/sars_sequencer_test.sv
`timescale 1ns/1ps
`include "sars_params.svh"
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin miscompares++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, exp, got); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 3000) begin @(posedge aclk); n++; end end
module sars_sequencer_test;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [9:0] offset = 10'h000;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, rd;
    logic adc_en, sample_hold, comp_in, core_int, irq, sh_q, ci_q;
    logic [4:0] mux_sel;
    logic [9:0] sar_code;
    logic [1:0] rs;
    logic [4:0] seq[$];
    int miscompares = 0;
    int cmp_count = 0;
    int cyc = 0;
    int n, k, rises;
    // chan, comparator offset, expected code
    logic [24:0] rows [5] = '{{5'h00, 10'h000, 10'h000}, {5'h05, 10'h123, 10'h27C},
        {5'h0B, 10'h3FF, 10'h2F6}, {5'h1F, 10'h0A0, 10'h0FB}, {5'h00, 10'h3FF, 10'h3FF}};

    sars_sequencer dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_en, .mux_sel, .sample_hold,
        .sar_code, .comp_in, .core_int, .irq);
    sars_adc_model adc (.aclk, .adc_en, .mux_sel, .sample_hold, .sar_code, .offset, .comp_in);

    always #5 aclk = ~aclk;

    function automatic logic [9:0] lvl(input logic [4:0] c, input logic [9:0] o);
        return 10'({5'h00, c} * 10'h045 + o);
    endfunction

    task end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
    endtask

    task rdr(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task sweep_check(input logic [9:0] o);
        // two wraps: the first may close a sweep begun under the old input level
        repeat (2) begin
            wr(`SARS_INT_STAT_OFS, 32'h7);
            n = 0;
            do begin
                rdr(`SARS_INT_STAT_OFS);
                n++;
            end while (!rd[2] && n < 300);
        end
        for (int i = 0; i < 12; i++) begin
            rdr(8'(`SARS_RES_BASE_OFS + 4 * i));
            `CHK("result", lvl(5'(i), o), rd[9:0])
        end
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        sh_q <= sample_hold;
        ci_q <= core_int;
        if (sample_hold && !sh_q) seq.push_back(mux_sel);
        if (core_int && !ci_q) rises++;
        if (cyc == 40000) begin
            miscompares++;
            end_of_test();
        end
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        `CHK("adc_en", 1'b0, adc_en)
        `CHK("core_int", 1'b0, core_int)
        rdr(`SARS_SETTLE_OFS);
        `CHK("settle rst", 16'h0064, rd[15:0])
        // 6319 + 12 + 2 cycles of 10 ns is the 63.33 us channel time
        rdr(`SARS_SAMPLE_OFS);
        `CHK("sample rst", 16'h18AF, rd[15:0])
        rdr(8'h30);
        `CHK("unmapped", 34'h200000000, {rs, rd})
        wr(`SARS_SETTLE_OFS, 32'h2);
        wr(`SARS_SAMPLE_OFS, 32'h3);
        wr(`SARS_INT_MASK_OFS, 32'h1);
        for (int i = 0; i < 5; i++) begin
            offset <= rows[i][19:10];
            wr(`SARS_CTRL_OFS, {1'b1, 22'h0, rows[i][24:20], 4'h1});
            `WAITC(sample_hold)
            k = 0;
            while (sample_hold && k < 100) begin
                @(posedge aclk);
                k++;
            end
            `CHK("sample len", 3, k)
            `WAITC(core_int)
            `CHK("sar code", rows[i][9:0], sar_code)
            `CHK("mux", rows[i][24:20], mux_sel)
            rdr(`SARS_SINGLE_RES_OFS);
            `CHK("single result", rows[i][9:0], rd[9:0])
            `CHK("irq", 1'b1, irq)
            wr(`SARS_INT_STAT_OFS, 32'h1);
            repeat (2) @(posedge aclk);
            `CHK("irq clear", 1'b0, irq)
        end
        // masked event: status still set, no interrupt line
        wr(`SARS_INT_MASK_OFS, 32'h0);
        wr(`SARS_CTRL_OFS, 32'h80000001);
        `WAITC(core_int)
        repeat (4) @(posedge aclk);
        `CHK("masked irq", 1'b0, irq)
        rdr(`SARS_INT_STAT_OFS);
        `CHK("conv stat", 1'b1, rd[0])
        // continuous, then disable while sampling
        offset <= 10'h155;
        wr(`SARS_CTRL_OFS, 32'h80000039);
        `WAITC(core_int)
        `WAITC(!core_int)
        `CHK("restart", 1'b1, sample_hold)
        wr(`SARS_CTRL_OFS, 32'h0);
        `WAITC(core_int)
        `CHK("last conv", 1'b1, core_int)
        `WAITC(!adc_en)
        rdr(`SARS_SINGLE_RES_OFS);
        `CHK("cont result", 10'h224, rd[9:0])
        // round robin: order, results, overwrite
        offset <= 10'h0F0;
        seq.delete();
        // averaging is not modelled: every conversion is one sample
        wr(`SARS_CTRL_OFS, 32'h3);
        sweep_check(10'h0F0);
        offset <= 10'h20A;
        sweep_check(10'h20A);
        sweep_check(10'h20A);
        for (int i = 0; i < 13; i++) begin
            `CHK("rr order", 5'(i % 12), seq[i])
        end
        wr(`SARS_CTRL_OFS, 32'h0);
        `WAITC(!adc_en)
        // one-time sweep
        offset <= 10'h011;
        wr(`SARS_INT_STAT_OFS, 32'h7);
        seq.delete();
        rises = 0;
        wr(`SARS_CTRL_OFS, 32'h80000005);
        `WAITC(core_int)
        `CHK("once chan", 5'h0B, mux_sel)
        repeat (100) @(posedge aclk);
        `CHK("once ints", 1, rises)
        `CHK("once count", 12, seq.size())
        rdr(`SARS_INT_STAT_OFS);
        `CHK("once stat", 1'b1, rd[1])
        rdr(8'h6C);
        `CHK("once last", lvl(5'h0B, 10'h011), rd[9:0])
        wr(8'h3C, 32'h1);
        `CHK("bad write", 2'h2, rs)
        wr(`SARS_CTRL_OFS, 32'h7);
        rdr(`SARS_CTRL_OFS);
        `CHK("mode keep", 32'h5, rd)
        end_of_test();
    end
endmodule

bind sars_sequencer sars_sequencer_checker chk (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .adc_en, .mux_sel, .sample_hold, .core_int);
